// ==== rtl/sfp_consts.svh ====
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH

// ****************************************************
// Opcodes, shifted most significant bit first
// ****************************************************
`define SFP_OP_WRITE_ENABLE 8'h06
`define SFP_OP_WRITE_DISABLE 8'h04
`define SFP_OP_STATUS_READ 8'h05
`define SFP_OP_STATUS_WRITE 8'h01
`define SFP_OP_READ 8'h03
`define SFP_OP_FAST_READ 8'h0b
`define SFP_OP_PAGE_PROGRAM 8'h02

// ****************************************************
// Status byte field positions
// ****************************************************
`define SFP_SR_PIN_EN 7
`define SFP_SR_BP_HI 3
`define SFP_SR_BP_LO 2
`define SFP_SR_WEL 1
`define SFP_SR_BUSY 0

// ****************************************************
// Protected range starts, array top is 18'h3ffff
// ****************************************************
`define SFP_PROT_QUARTER 18'h30000
`define SFP_PROT_HALF 18'h20000
`define SFP_PROT_ALL 18'h00000

// ****************************************************
// Reset values and timing counts
// ****************************************************
`define SFP_CFG_RESET 3'h0
`define SFP_PROG_CYCLES 1000
`define SFP_STATUS_CYCLES 100
`define SFP_FIFO_DEPTH 16

`endif

// ==== rtl/sfp_flash.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sfp_consts.svh"

// ****************************************************
// Read prefetch FIFO
// ****************************************************
module sfp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SFP_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH]; // Entry storage
  logic [AW:0] wrPtr_q; // Write pointer with wrap bit
  logic [AW:0] rdPtr_q; // Read pointer with wrap bit
  wire logic push = inValid & inReady;
  wire logic pop = outValid & outReady;

  // Honest full and empty
  assign inReady = (wrPtr_q[AW-1:0] != rdPtr_q[AW-1:0]) ||
                   (wrPtr_q[AW] == rdPtr_q[AW]);
  assign outValid = wrPtr_q != rdPtr_q;
  assign outData = store[rdPtr_q[AW-1:0]];

  // Pointers, cleared by flush
  always_ff @(posedge sys_clk) begin
    if (srst || flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + 1'b1;
      if (pop) rdPtr_q <= rdPtr_q + 1'b1;
    end
  end

  // Storage write
  always_ff @(posedge sys_clk) begin
    if (push) store[wrPtr_q[AW-1:0]] <= inData;
  end
endmodule

// Contract
// - Power-up leaves write enable latch cleared
// - Write disable clears latch regardless of pin
// - Block bits select none, quarter, half, all
// - Protected range read-only; others need latch
// - Pin low and enable bit set blocks status
// - Enable bit cannot clear while pin low
// - Status write needs latch and pin permission
// - Read takes 3-byte address, shifts data out
// - Read address increments and wraps around
// - Chip select high ends read output
// - Read rejected during any running cycle
// - Fast read waits one dummy byte first
// - Fast read rejected during running cycle
// - Busy cycle ignores all but status read
// - Select rise starts timed cycle, busy set
// - Program 1-256 bytes, clear bits, page wrap
// - Cycle end leaves device write disabled
// - Program without latch ignored at select rise
// - Program to protected page not executed
// - MSB first; fixed opcode values
// - Status byte layout, bits six-four zero
// - Deselected: input ignored, output floating
module sfp_flash #(
  parameter int PROG_CYCLES = `SFP_PROG_CYCLES,
  parameter int STATUS_CYCLES = `SFP_STATUS_CYCLES,
  parameter int FIFO_DEPTH = `SFP_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic serialClk,
  input wire logic chipSelectN,
  input wire logic serialIn,
  input wire logic writeProtectN,
  output logic serialOut,
  output logic serialOutOe,
  output logic [7:0] statusByte,
  output logic busy
);
  localparam logic [15:0] PROG_LAST = 16'(PROG_CYCLES - 1);
  localparam logic [15:0] STAT_LAST = 16'(STATUS_CYCLES - 1);

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic sckS1_q, sckS2_q, sckS3_q; // Serial clock stages
  logic csS1_q, csS2_q, csS3_q; // Chip select stages
  logic siS1_q, siS2_q; // Serial input stages
  logic wpS1_q, wpS2_q; // Write protect stages

  // Two flops per pin, third for edges
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      {sckS1_q, sckS2_q, sckS3_q} <= 3'h0;
      {csS1_q, csS2_q, csS3_q} <= 3'h7;
      {siS1_q, siS2_q, wpS1_q, wpS2_q} <= 4'h0;
    end else begin
      sckS1_q <= serialClk;
      sckS2_q <= sckS1_q;
      sckS3_q <= sckS2_q;
      csS1_q <= chipSelectN;
      csS2_q <= csS1_q;
      csS3_q <= csS2_q;
      siS1_q <= serialIn;
      siS2_q <= siS1_q;
      wpS1_q <= writeProtectN;
      wpS2_q <= wpS1_q;
    end
  end

  // Serial clock edges count only while selected
  wire logic selected = ~csS2_q;
  wire logic sckRise = selected & sckS2_q & ~sckS3_q;
  wire logic sckFall = selected & ~sckS2_q & sckS3_q;
  wire logic csRise = csS2_q & ~csS3_q;

  // ****************************************************
  // State
  // ****************************************************
  sfp_pkg::sfp_phase_e phase_q, phase_d; // Transaction phase
  sfp_pkg::sfp_cycle_e cycle_q; // Running self-timed cycle
  sfp_pkg::sfp_cfg_s cfg_q; // Stored protection bits
  logic wel_q; // Write enable latch
  logic [7:0] cmd_q; // Decoded opcode
  logic [7:0] shiftIn_q; // Input shifter
  logic [2:0] bitCnt_q; // Bit in byte
  logic [1:0] addrCnt_q; // Address byte count
  logic [17:0] addr_q; // Collected address
  logic [7:0] newStatus_q; // Received status byte
  logic gotByte_q; // Program data seen
  logic [17:0] rdAddr_q; // Prefetch address
  logic readOn_q; // Prefetch running
  logic statOut_q; // Output is status byte
  logic [7:0] outShift_q; // Output shifter
  logic [2:0] outLeft_q; // Output bits left
  logic [15:0] cycCnt_q; // Cycle timer
  logic [9:0] progPage_q; // Page under program
  logic [7:0] pageBuf [256]; // Page data latch
  logic [255:0] pageValid_q; // Bytes loaded in page
  logic [7:0] mem [262144]; // Flash array

  // ****************************************************
  // Decode
  // ****************************************************
  wire logic [7:0] rxByte = {shiftIn_q[6:0], siS2_q};
  wire logic byteDone = sckRise & (bitCnt_q == 3'h7);
  wire logic isBusy = cycle_q != sfp_pkg::CYC_NONE;
  wire logic [1:0] bp = {cfg_q.blockProtectHi, cfg_q.blockProtectLo};
  wire logic [17:0] protStart = (bp == 2'h1) ? `SFP_PROT_QUARTER :
                                (bp == 2'h2) ? `SFP_PROT_HALF :
                                `SFP_PROT_ALL;
  wire logic [17:0] progBase = {addr_q[17:8], 8'h00};
  wire logic protHit = (bp != 2'h0) && (progBase >= protStart);
  wire logic hwProt = ~wpS2_q & cfg_q.pinProtectEnable;
  wire logic srWriteOk = wel_q & ~hwProt;
  wire logic cmdWrEn = cmd_q == `SFP_OP_WRITE_ENABLE;
  wire logic cmdWrDis = cmd_q == `SFP_OP_WRITE_DISABLE;
  wire logic cmdSrWr = cmd_q == `SFP_OP_STATUS_WRITE;
  wire logic endDone = csRise & (phase_q == sfp_pkg::PH_DONE);
  wire logic startStat = endDone & cmdSrWr & srWriteOk;
  wire logic startProg = csRise & (phase_q == sfp_pkg::PH_PROG_IN) &
                         (bitCnt_q == 3'h0) & gotByte_q & wel_q &
                         ~protHit;
  wire logic [17:0] progAddr = {progPage_q, cycCnt_q[7:0]};
  wire logic progWrite = (cycle_q == sfp_pkg::CYC_PROG) &&
                         (cycCnt_q[15:8] == 8'h00) &&
                         pageValid_q[cycCnt_q[7:0]];
  wire logic cycEnd = ((cycle_q == sfp_pkg::CYC_PROG) &&
                       (cycCnt_q == PROG_LAST)) ||
                      ((cycle_q == sfp_pkg::CYC_STAT) &&
                       (cycCnt_q == STAT_LAST));

  // Status byte, bits six to four zero
  assign statusByte = {cfg_q.pinProtectEnable, 3'h0,
                       bp, wel_q, isBusy};
  assign busy = isBusy;

  // ****************************************************
  // Read prefetch path
  // ****************************************************
  sfp_pkg::sfp_rd_s fifoIn, fifoOut;
  logic fifoInReady, fifoOutValid;
  wire logic inData = phase_q == sfp_pkg::PH_DATA_OUT;
  wire logic popByte = sckFall & inData & (outLeft_q == 3'h0) &
                       ~statOut_q;
  wire logic pushByte = readOn_q & fifoInReady;
  assign fifoIn.data = mem[rdAddr_q];

  sfp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) uFifo (
    .sys_clk(sys_clk),
    .srst(srst),
    .flush(csS2_q),
    .inValid(readOn_q),
    .inReady(fifoInReady),
    .inData(fifoIn),
    .outValid(fifoOutValid),
    .outReady(popByte),
    .outData(fifoOut)
  );

  // ****************************************************
  // Phase next state
  // ****************************************************
  always_comb begin
    phase_d = phase_q;
    if (byteDone) begin
      unique case (phase_q)
        sfp_pkg::PH_CMD: begin
          if (rxByte == `SFP_OP_STATUS_READ) begin
            phase_d = sfp_pkg::PH_DATA_OUT;
          end else if (isBusy) begin
            phase_d = sfp_pkg::PH_IGNORE;
          end else if (rxByte == `SFP_OP_WRITE_ENABLE ||
                       rxByte == `SFP_OP_WRITE_DISABLE) begin
            phase_d = sfp_pkg::PH_DONE;
          end else if (rxByte == `SFP_OP_STATUS_WRITE) begin
            phase_d = sfp_pkg::PH_STAT_IN;
          end else if (rxByte == `SFP_OP_READ ||
                       rxByte == `SFP_OP_FAST_READ ||
                       rxByte == `SFP_OP_PAGE_PROGRAM) begin
            phase_d = sfp_pkg::PH_ADDR;
          end else begin
            phase_d = sfp_pkg::PH_IGNORE;
          end
        end
        sfp_pkg::PH_ADDR: begin
          if (addrCnt_q == 2'h2) begin
            if (cmd_q == `SFP_OP_READ) begin
              phase_d = sfp_pkg::PH_DATA_OUT;
            end else if (cmd_q == `SFP_OP_FAST_READ) begin
              phase_d = sfp_pkg::PH_DUMMY;
            end else begin
              phase_d = sfp_pkg::PH_PROG_IN;
            end
          end
        end
        sfp_pkg::PH_DUMMY: phase_d = sfp_pkg::PH_DATA_OUT;
        sfp_pkg::PH_STAT_IN: phase_d = sfp_pkg::PH_DONE;
        sfp_pkg::PH_DATA_OUT, sfp_pkg::PH_PROG_IN,
        sfp_pkg::PH_DONE, sfp_pkg::PH_IGNORE: phase_d = phase_q;
      endcase
    end
    if (csS2_q) phase_d = sfp_pkg::PH_CMD;
  end

  // ****************************************************
  // Serial receive
  // ****************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      phase_q <= sfp_pkg::PH_CMD;
      shiftIn_q <= 8'h00;
      bitCnt_q <= 3'h0;
      addrCnt_q <= 2'h0;
      cmd_q <= 8'h00;
      addr_q <= 18'h00000;
      newStatus_q <= 8'h00;
      gotByte_q <= 1'b0;
      statOut_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      if (csS2_q) begin
        bitCnt_q <= 3'h0;
        addrCnt_q <= 2'h0;
        gotByte_q <= 1'b0;
      end else if (sckRise) begin
        shiftIn_q <= rxByte;
        bitCnt_q <= bitCnt_q + 3'h1;
      end
      if (byteDone && phase_q == sfp_pkg::PH_CMD) begin
        cmd_q <= rxByte;
        statOut_q <= rxByte == `SFP_OP_STATUS_READ;
      end
      if (byteDone && phase_q == sfp_pkg::PH_ADDR) begin
        addr_q <= {addr_q[9:0], rxByte};
        addrCnt_q <= addrCnt_q + 2'h1;
      end
      if (byteDone && phase_q == sfp_pkg::PH_STAT_IN) begin
        newStatus_q <= rxByte;
      end
      if (byteDone && phase_q == sfp_pkg::PH_PROG_IN) begin
        addr_q[7:0] <= addr_q[7:0] + 8'h01;
        gotByte_q <= 1'b1;
      end
    end
  end

  // ****************************************************
  // Prefetch address and serial output
  // ****************************************************
  always_ff @(posedge sys_clk) begin
    if (srst || csS2_q) begin
      readOn_q <= 1'b0;
      rdAddr_q <= 18'h00000;
      outShift_q <= 8'h00;
      outLeft_q <= 3'h0;
    end else begin
      if (byteDone && phase_q == sfp_pkg::PH_ADDR &&
          addrCnt_q == 2'h2 && cmd_q != `SFP_OP_PAGE_PROGRAM) begin
        readOn_q <= 1'b1;
        rdAddr_q <= {addr_q[9:0], rxByte};
      end else if (pushByte) begin
        rdAddr_q <= rdAddr_q + 18'h00001;
      end
      if (sckFall && inData) begin
        if (outLeft_q == 3'h0) begin
          outShift_q <= statOut_q ? statusByte : fifoOut.data;
          outLeft_q <= 3'h7;
        end else begin
          outShift_q <= {outShift_q[6:0], 1'b0};
          outLeft_q <= outLeft_q - 3'h1;
        end
      end
    end
  end

  // Output floats unless shifting data
  assign serialOut = outShift_q[7];
  assign serialOutOe = selected & inData;

  // ****************************************************
  // Latch, protection bits and cycle timer
  // ****************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wel_q <= 1'b0;
      cfg_q <= `SFP_CFG_RESET;
      cycle_q <= sfp_pkg::CYC_NONE;
      cycCnt_q <= 16'h0000;
      progPage_q <= 10'h000;
    end else begin
      if (endDone && cmdWrEn) wel_q <= 1'b1;
      if (endDone && cmdWrDis) wel_q <= 1'b0;
      if (startStat) begin
        cfg_q.pinProtectEnable <= newStatus_q[`SFP_SR_PIN_EN];
        cfg_q.blockProtectHi <= newStatus_q[`SFP_SR_BP_HI];
        cfg_q.blockProtectLo <= newStatus_q[`SFP_SR_BP_LO];
        cycle_q <= sfp_pkg::CYC_STAT;
        wel_q <= 1'b0;
      end else if (startProg) begin
        cycle_q <= sfp_pkg::CYC_PROG;
        progPage_q <= addr_q[17:8];
        wel_q <= 1'b0;
      end
      if (cycEnd) begin
        cycle_q <= sfp_pkg::CYC_NONE;
        cycCnt_q <= 16'h0000;
      end else if (isBusy) begin
        cycCnt_q <= cycCnt_q + 16'h0001;
      end
    end
  end

  // ****************************************************
  // Page latch and array
  // ****************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pageValid_q <= '0;
    end else if (byteDone && phase_q == sfp_pkg::PH_CMD &&
                 !isBusy) begin
      pageValid_q <= '0;
    end else if (byteDone && phase_q == sfp_pkg::PH_PROG_IN) begin
      pageValid_q[addr_q[7:0]] <= 1'b1;
    end
  end

  // Later bytes overwrite wrapped ones
  always_ff @(posedge sys_clk) begin
    if (byteDone && phase_q == sfp_pkg::PH_PROG_IN) begin
      pageBuf[addr_q[7:0]] <= rxByte;
    end
  end

  // Programming only clears bits
  always_ff @(posedge sys_clk) begin
    if (progWrite) begin
      mem[progAddr] <= mem[progAddr] & pageBuf[cycCnt_q[7:0]];
    end
  end

  // Array starts erased
  initial begin
    for (int i = 0; i < 262144; i++) mem[i] = 8'hff;
  end
endmodule
`default_nettype wire

// ==== rtl/sfp_pkg.sv ====
package sfp_pkg;

  // Serial transaction phase
  typedef enum logic [2:0] {
    PH_CMD, PH_ADDR, PH_DUMMY, PH_DATA_OUT,
    PH_PROG_IN, PH_STAT_IN, PH_DONE, PH_IGNORE
  } sfp_phase_e;

  // Self-timed cycle kind
  typedef enum logic [1:0] {CYC_NONE, CYC_PROG, CYC_STAT} sfp_cycle_e;

  // Nonvolatile status bits
  typedef struct packed {
    logic pinProtectEnable;
    logic blockProtectHi;
    logic blockProtectLo;
  } sfp_cfg_s;

  // Read prefetch word
  typedef struct packed {
    logic [7:0] data;
  } sfp_rd_s;

endpackage

// ==== verification/sfp_flash_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none

// ****************************************************
// Port checks of the flash command logic
// ****************************************************
module sfp_flash_assertions #(
  parameter int PROG_CYCLES = 1000,
  parameter int STATUS_CYCLES = 100,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic serialClk,
  input wire logic chipSelectN,
  input wire logic serialIn,
  input wire logic writeProtectN,
  input wire logic serialOut,
  input wire logic serialOutOe,
  input wire logic [7:0] statusByte,
  input wire logic busy
);
  // Longest legal self-timed cycle plus slack
  localparam int BUSY_MAX =
    ((PROG_CYCLES > STATUS_CYCLES) ? PROG_CYCLES : STATUS_CYCLES) + 2;
  int busyCnt; // Length of the running cycle so far

  default clocking cb @(posedge sys_clk); endclocking

  // Counts cycles while busy stands
  always_ff @(posedge sys_clk) begin
    busyCnt <= (srst || !busy) ? 0 : busyCnt + 1;
  end

  a_reset_state: assert property (disable iff (1'b0)
    srst |=> statusByte == 8'h00 && !busy && !serialOutOe)
    else $error("state not cleared by reset");
  a_zero_bits: assert property (disable iff (srst)
    statusByte[6:4] == 3'h0)
    else $error("unused status bits not zero");
  a_busy_mirror: assert property (disable iff (srst)
    statusByte[0] == busy)
    else $error("busy bit differs from busy");
  a_desel_float: assert property (disable iff (srst)
    chipSelectN [*5] |-> !serialOutOe)
    else $error("output driven while deselected");
  a_busy_needs_wel: assert property (disable iff (srst)
    $rose(busy) |-> $past(statusByte[1]))
    else $error("cycle started without latch");
  a_busy_wel_clr: assert property (disable iff (srst)
    busy |-> !statusByte[1])
    else $error("latch set during a cycle");
  a_start_at_cs: assert property (disable iff (srst)
    $rose(busy) |-> chipSelectN && $past(chipSelectN, 3))
    else $error("cycle started while selected");
  a_busy_bounded: assert property (disable iff (srst)
    busyCnt <= BUSY_MAX)
    else $error("self-timed cycle too long");
  a_pin_lock: assert property (disable iff (srst)
    (!writeProtectN && !busy) [*6] |=> !$fell(statusByte[7]))
    else $error("pin enable cleared while pin low");
endmodule

bind sfp_flash sfp_flash_assertions #(.PROG_CYCLES(PROG_CYCLES),
  .STATUS_CYCLES(STATUS_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) i_chk (
  .sys_clk(sys_clk), .srst(srst), .serialClk(serialClk),
  .chipSelectN(chipSelectN), .serialIn(serialIn),
  .writeProtectN(writeProtectN), .serialOut(serialOut),
  .serialOutOe(serialOutOe), .statusByte(statusByte), .busy(busy));

`default_nettype wire

// ==== verification/sfp_flash_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sfp_consts.svh"

// ****************************************************
// Compare helper
// ****************************************************
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); \
  err_total++; end end

module sfp_flash_tb;
  localparam int PCYC = 2000; // Program time, long enough to overlap reads
  localparam int SCYC = 20; // Shortened status write time
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic writeProtectN = 1'b1;
  logic serialClk, chipSelectN, serialIn, serialOut, serialOutOe, busy;
  logic [7:0] statusByte;
  logic [7:0] rx; // Last byte seen by the host
  logic [7:0] mem [logic [17:0]]; // Expected array, erased is ff
  logic [17:0] pa; // Program target
  int err_total = 0;
  int n_checks = 0;

  // 50 MHz system clock
  always #10 sys_clk = ~sys_clk;

  sfp_flash #(.PROG_CYCLES(PCYC), .STATUS_CYCLES(SCYC)) i_dut (
    .sys_clk(sys_clk), .srst(srst), .serialClk(serialClk),
    .chipSelectN(chipSelectN), .serialIn(serialIn),
    .writeProtectN(writeProtectN), .serialOut(serialOut),
    .serialOutOe(serialOutOe), .statusByte(statusByte), .busy(busy));

  sfp_host_model i_host (.sys_clk(sys_clk), .serialClk(serialClk),
    .chipSelectN(chipSelectN), .serialIn(serialIn),
    .serialOut(serialOut), .serialOutOe(serialOutOe));

  // Expected byte at an address
  function automatic logic [7:0] expAt(input logic [17:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction

  // Protected range per block bits
  function automatic bit prot(input logic [1:0] bp, input logic [17:0] a);
    return bp == 2'h3 || (bp == 2'h2 && a >= 18'h20000) ||
      (bp == 2'h1 && a >= 18'h30000);
  endfunction

  // Single opcode frame
  task automatic cmd(input logic [7:0] op);
    i_host.sel();
    i_host.xb(op, rx);
    i_host.desel();
  endtask

  // Address bytes, ignored top bits set to ones
  task automatic addr(input logic [17:0] a);
    i_host.xb({6'h3f, a[17:16]}, rx);
    i_host.xb(a[15:8], rx);
    i_host.xb(a[7:0], rx);
  endtask

  // Status write frame
  task automatic wstat(input logic [7:0] v);
    i_host.sel();
    i_host.xb(`SFP_OP_STATUS_WRITE, rx);
    i_host.xb(v, rx);
    i_host.desel();
  endtask

  // Bounded wait for the end of a cycle
  task automatic idle();
    for (int k = 0; k < PCYC + 100 && busy !== 1'b0; k++) begin
      @(negedge sys_clk);
    end
    `CHK(busy, 1'b0)
  endtask

  // Page program of n bytes, data d xor index
  task automatic prog(input logic [17:0] a, input int n, input logic [7:0] d,
                      input bit ok);
    logic wl; // Latch level before the frame
    wl = statusByte[1];
    i_host.sel();
    i_host.xb(`SFP_OP_PAGE_PROGRAM, rx);
    addr(a);
    for (int i = 0; i < n; i++) i_host.xb(d ^ 8'(i), rx);
    i_host.desel();
    `CHK(busy, ok)
    for (int i = 0; i < n && ok; i++) begin
      pa = {a[17:8], 8'(a[7:0] + 8'(i))};
      mem[pa] = expAt(pa) & (d ^ 8'(i));
    end
    idle();
    `CHK(statusByte[1], ok ? 1'b0 : wl)
  endtask

  // Normal or fast read of n bytes
  task automatic rd(input logic [17:0] a, input int n, input bit fast);
    i_host.sel();
    i_host.xb(fast ? `SFP_OP_FAST_READ : `SFP_OP_READ, rx);
    addr(a);
    if (fast) i_host.xb(8'h5a, rx);
    for (int i = 0; i < n; i++) begin
      i_host.xb(8'h00, rx);
      `CHK(rx, expAt(a + 18'(i)))
    end
    i_host.desel();
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (90000) @(posedge sys_clk);
    err_total++;
    conclude();
  end

  // Test sequence
  initial begin
    repeat (6) @(negedge sys_clk);
    srst = 1'b0;
    repeat (4) @(negedge sys_clk);
    `CHK(statusByte, 8'h00)
    `CHK(serialOutOe, 1'b0)
    $display("test reset done");
    cmd(`SFP_OP_WRITE_ENABLE);
    `CHK(statusByte, 8'h02)
    writeProtectN = 1'b0;
    cmd(`SFP_OP_WRITE_DISABLE);
    `CHK(statusByte, 8'h00)
    writeProtectN = 1'b1;
    $display("test latch done");
    prog(18'h00100, 1, 8'h5a, 1'b0);
    cmd(`SFP_OP_WRITE_ENABLE);
    prog(18'h001fe, 3, 8'ha5, 1'b1);
    cmd(`SFP_OP_WRITE_ENABLE);
    prog(18'h00100, 1, 8'hf0, 1'b1);
    rd(18'h001fe, 3, 1'b0);
    rd(18'h00100, 1, 1'b1);
    rd(18'h3ffff, 2, 1'b1);
    $display("test array done");
    cmd(`SFP_OP_WRITE_ENABLE);
    i_host.sel();
    i_host.xb(`SFP_OP_PAGE_PROGRAM, rx);
    addr(18'h00010);
    i_host.xb(8'h12, rx);
    i_host.desel();
    mem[18'h00010] = 8'h12;
    cmd(`SFP_OP_WRITE_ENABLE);
    for (int f = 0; f < 2; f++) begin
      i_host.sel();
      i_host.xb(f ? `SFP_OP_FAST_READ : `SFP_OP_READ, rx);
      addr(18'h00010);
      if (f) i_host.xb(8'h00, rx);
      i_host.xb(8'h00, rx);
      `CHK(serialOutOe, 1'b0)
      i_host.desel();
    end
    `CHK(busy, 1'b1)
    idle();
    `CHK(statusByte[1], 1'b0)
    rd(18'h00010, 1, 1'b0);
    $display("test busy done");
    for (int bp = 0; bp < 4; bp++) begin
      cmd(`SFP_OP_WRITE_ENABLE);
      wstat({4'h0, 2'(bp), 2'h0});
      idle();
      `CHK(statusByte, {4'h0, 2'(bp), 2'h0})
      for (int j = 0; j < 2; j++) begin
        cmd(`SFP_OP_WRITE_ENABLE);
        pa = j ? 18'h30000 : 18'h2ffff;
        prog(pa, 1, 8'h7e ^ 8'(bp), !prot(2'(bp), pa));
      end
    end
    rd(18'h2ffff, 2, 1'b0);
    $display("test protect done");
    cmd(`SFP_OP_WRITE_ENABLE);
    wstat(8'h80);
    idle();
    `CHK(statusByte, 8'h80)
    writeProtectN = 1'b0;
    cmd(`SFP_OP_WRITE_ENABLE);
    wstat(8'h00);
    `CHK(busy, 1'b0)
    `CHK(statusByte[7:2], 6'h20)
    writeProtectN = 1'b1;
    cmd(`SFP_OP_WRITE_DISABLE);
    wstat(8'h0c);
    `CHK(statusByte, 8'h80)
    cmd(`SFP_OP_WRITE_ENABLE);
    wstat(8'h00);
    idle();
    `CHK(statusByte, 8'h00)
    $display("test pin done");
    conclude();
  end
endmodule

`default_nettype wire

// ==== verification/sfp_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// ****************************************************
// Host side of the serial link, mode 0
// ****************************************************
module sfp_host_model (
  input wire logic sys_clk,
  output logic serialClk,
  output logic chipSelectN,
  output logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutOe
);
  localparam int HALF = 6; // Half link period in system clocks

  // Idle levels
  initial begin
    serialClk = 1'b0;
    chipSelectN = 1'b1;
    serialIn = 1'b0;
  end

  // Waits on falling system edges
  task automatic gap(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Starts a frame
  task automatic sel();
    gap(4);
    chipSelectN = 1'b0;
    gap(HALF);
  endtask

  // Ends a frame in clock low, right after the last bit
  task automatic desel();
    gap(2);
    chipSelectN = 1'b1;
    serialIn = ~serialIn; // Released line shows no stale bit
    gap(8);
  endtask

  // One byte each way, most significant bit first
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serialIn = tx[i];
      gap(HALF);
      serialClk = 1'b1;
      rx[i] = serialOutOe ? serialOut : 1'bx;
      gap(HALF);
      serialClk = 1'b0;
    end
  endtask
endmodule

`default_nettype wire
